/* rtl/scc_pkg.sv */
`default_nettype none
package scc_pkg;

  // Sleep mode encoding
  typedef enum logic [2:0] {
    SCC_MODE_IDLE = 3'h0,
    SCC_MODE_PDOWN = 3'h2,
    SCC_MODE_PSAVE = 3'h3,
    SCC_MODE_STDBY = 3'h6,
    SCC_MODE_ESTDBY = 3'h7
  } scc_mode_e;

  // Controller states, Gray along active -> drain -> sleep -> wake -> active
  typedef enum logic [1:0] {
    SCC_ST_ACTIVE = 2'h0,
    SCC_ST_DRAIN = 2'h1,
    SCC_ST_SLEEP = 2'h3,
    SCC_ST_WAKE = 2'h2
  } scc_state_e;

  // Wake sources grouped
  typedef struct packed {
    logic wire_match;
    logic async_pin;
    logic usb_resume;
    logic other_irq;
  } scc_wake_s;

  // Gated clock enables
  typedef struct packed {
    logic cpu;
    logic nvm;
    logic periph;
    logic rtc;
  } scc_clk_s;

  localparam int SCC_WAKE_HALT_CYC = 4;
  localparam logic [2:0] SCC_HALT_CNT_W_RST = 3'h0;
  localparam logic [2:0] SCC_MODE_RST = 3'h0;
  localparam logic [3:0] SCC_PSAVE_STOP = 4'hC;
  localparam logic [3:0] SCC_STDBY_STOP = 4'hC;
  localparam logic [3:0] SCC_ESTDBY_STOP = 4'hC;
  localparam logic [3:0] SCC_IDLE_STOP = 4'hC;
  localparam logic [3:0] SCC_PDOWN_STOP = 4'hF;
  localparam logic [3:0] SCC_CLK_RST = 4'hF;

endpackage : scc_pkg
`default_nettype wire

/* rtl/scc_periph_gate.sv */
`timescale 1ns/1ns
`default_nettype none
module scc_periph_gate
  import scc_pkg::*;
#(
  parameter int NUM_PERIPH = 8
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Control
  input wire logic [NUM_PERIPH-1:0] reduce_i,
  input wire logic periph_run_i,
  // Gated enables
  output logic [NUM_PERIPH-1:0] periph_clk_en_o
);

  logic [NUM_PERIPH-1:0] en_r;
  logic [NUM_PERIPH-1:0] en_nxt;

  generate
    for (genvar g = 0; g < NUM_PERIPH; g++)
    begin : g_per
      // Stopped clock freezes state in place; no reset pulse is sent
      always_comb
      begin
        en_nxt[g] = periph_run_i & ~reduce_i[g]; // see R16 see R17
      end
    end
  endgenerate

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      en_r <= '0;
    else
      en_r <= en_nxt;
  end

  assign periph_clk_en_o = en_r;

endmodule : scc_periph_gate
`default_nettype wire

/* rtl/scc_sleep_ctrl.sv */
// Operation
// R01 - Five sleep modes selectable: idle, power-down, power-save, standby, extended standby.
// R02 - Sleep may only be entered from active mode.
// R03 - Sleep instruction stops execution until an interrupt or reset wakes.
// R04 - Enabled peripheral interrupts and enabled resets return the device to active.
// R05 - Permitted wake sources depend on the configured sleep mode.
// R06 - Wake interrupt service runs, then code resumes after the sleep instruction.
// R07 - Higher priority pending interrupts are serviced first, in priority order.
// R08 - Core stays halted four cycles after every wake-up; after a wake-up by reset the code releases the core at once.
// R09 - Register file, SRAM and registers keep contents while asleep.
// R10 - Reset during sleep restarts fully, from the reset vector.
// R11 - Idle stops core and nonvolatile clocks after ongoing programming finishes.
// R12 - Idle keeps peripherals, interrupt controller, events running; any enabled interrupt wakes.
// R13 - Power-down stops every clock including the real-time counter source.
// R14 - Power-down wakes only on address match, async pin, or USB resume.
// R15 - Two-wire slave address match wakes from every sleep mode.
// R16 - Power reduction bits stop individual peripheral clocks, freezing their state.
// R17 - Peripheral gating acts in active and idle regardless of selected mode.
// R18 - Mode held in software setting; sleep instruction needs software enable.
// R19 - Other modes' clock stops are parameters, default core and nonvolatile stopped.
`timescale 1ns/1ns
`default_nettype none
module scc_sleep_ctrl
  import scc_pkg::*;
#(
  parameter int NUM_PERIPH = 8,
  parameter logic [3:0] PSAVE_STOP = SCC_PSAVE_STOP,
  parameter logic [3:0] STDBY_STOP = SCC_STDBY_STOP,
  parameter logic [3:0] ESTDBY_STOP = SCC_ESTDBY_STOP
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Software configuration
  input wire logic sleep_en_i,
  input wire logic [2:0] sleep_mode_i,
  input wire logic [NUM_PERIPH-1:0] reduce_i,
  // Core side
  input wire logic sleep_instr_i,
  input wire logic nvm_busy_i,
  // Wake sources
  input wire scc_wake_s wake_i,
  // Core control
  output logic cpu_halt_o,
  output logic asleep_o,
  output logic wake_irq_o,
  output scc_clk_s clk_en_o,
  output logic [NUM_PERIPH-1:0] periph_clk_en_o
);

  // Refused at elaboration; a sleeping core must always lose its clock
  generate
    if (NUM_PERIPH < 1 || NUM_PERIPH > 64)
    begin : g_bad_periph
      $error("NUM_PERIPH out of range");
    end
    if (!PSAVE_STOP[3] || !STDBY_STOP[3] || !ESTDBY_STOP[3])
    begin : g_bad_stop
      $error("stop mask must stop the core clock");
    end
  endgenerate

  scc_state_e state_r, state_nxt;
  logic [2:0] mode_r, mode_nxt;
  logic [2:0] halt_cnt_r, halt_cnt_nxt;
  logic halt_r, halt_nxt;
  logic asleep_r, asleep_nxt;
  logic wirq_r, wirq_nxt;
  scc_clk_s clk_r, clk_nxt;
  logic mode_ok;
  logic wake_ok;
  logic [3:0] stop_set;

  // Mode decode: stop mask {cpu,nvm,periph,rtc}
  always_comb
  begin
    mode_ok = 1'b1; // see R01
    stop_set = SCC_IDLE_STOP;
    case (mode_r)
      SCC_MODE_IDLE: stop_set = SCC_IDLE_STOP; // see R11 see R12
      SCC_MODE_PDOWN: stop_set = SCC_PDOWN_STOP; // see R13
      SCC_MODE_PSAVE: stop_set = PSAVE_STOP; // see R19
      SCC_MODE_STDBY: stop_set = STDBY_STOP; // see R19
      SCC_MODE_ESTDBY: stop_set = ESTDBY_STOP; // see R19
      default: mode_ok = 1'b0;
    endcase
  end

  // Wake qualification per mode
  always_comb
  begin
    wake_ok = wake_i.wire_match; // see R15
    case (mode_r)
      SCC_MODE_PDOWN: wake_ok = wake_i.wire_match | wake_i.async_pin | wake_i.usb_resume; // see R14
      default: wake_ok = |wake_i; // see R04 see R05 see R12
    endcase
  end

  // Sleep sequence
  always_comb
  begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    halt_cnt_nxt = halt_cnt_r;
    halt_nxt = halt_r;
    asleep_nxt = asleep_r;
    wirq_nxt = 1'b0;
    clk_nxt = clk_r;
    case (state_r)
      SCC_ST_ACTIVE:
      begin
        mode_nxt = sleep_mode_i; // see R18
        halt_nxt = 1'b0;
        // Only entry point into sleep is from here
        if (sleep_instr_i && sleep_en_i && mode_ok) // see R02 see R18
        begin
          halt_nxt = 1'b1; // see R03
          state_nxt = SCC_ST_DRAIN;
        end
      end
      SCC_ST_DRAIN:
      begin
        // Let programming finish before the memory clock stops
        if (!nvm_busy_i) // see R11
        begin
          clk_nxt = scc_clk_s'(~stop_set);
          asleep_nxt = 1'b1;
          state_nxt = SCC_ST_SLEEP;
        end
      end
      SCC_ST_SLEEP:
      begin
        if (wake_ok) // see R04
        begin
          clk_nxt = scc_clk_s'(SCC_CLK_RST);
          asleep_nxt = 1'b0;
          halt_cnt_nxt = 3'(SCC_WAKE_HALT_CYC - 1);
          state_nxt = SCC_ST_WAKE;
        end
      end
      SCC_ST_WAKE:
      begin
        // Core then vectors by priority and returns after the instruction
        if (halt_cnt_r == 3'h0) // see R08
        begin
          halt_nxt = 1'b0;
          wirq_nxt = 1'b1; // see R06 see R07
          state_nxt = SCC_ST_ACTIVE;
        end
        else
          halt_cnt_nxt = halt_cnt_r - 3'h1;
      end
      default: state_nxt = SCC_ST_ACTIVE;
    endcase
  end

  // Reset only touches control state; storage is kept elsewhere
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i) // see R10 see R09
    begin
      state_r <= SCC_ST_ACTIVE;
      mode_r <= SCC_MODE_RST;
      halt_cnt_r <= SCC_HALT_CNT_W_RST;
      halt_r <= 1'b0;
      asleep_r <= 1'b0;
      wirq_r <= 1'b0;
      clk_r <= scc_clk_s'(SCC_CLK_RST);
    end
    else
    begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      halt_cnt_r <= halt_cnt_nxt;
      halt_r <= halt_nxt;
      asleep_r <= asleep_nxt;
      wirq_r <= wirq_nxt;
      clk_r <= clk_nxt;
    end
  end

  scc_periph_gate #(
    .NUM_PERIPH(NUM_PERIPH)
  ) u_gate (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .reduce_i(reduce_i),
    .periph_run_i(clk_nxt.periph), // see R17
    .periph_clk_en_o(periph_clk_en_o)
  );

  assign cpu_halt_o = halt_r;
  assign asleep_o = asleep_r;
  assign wake_irq_o = wirq_r;
  assign clk_en_o = clk_r;

  // Checking aid only: cycles spent halted with clocks back on
  logic [2:0] wake_len_r, wake_len_nxt;

  always_comb
  begin
    wake_len_nxt = wake_len_r;
    if (state_r == SCC_ST_SLEEP)
      wake_len_nxt = 3'h0;
    else if (state_r == SCC_ST_WAKE && wake_len_r != 3'h7)
      wake_len_nxt = wake_len_r + 3'h1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      wake_len_r <= 3'h0;
    else
      wake_len_r <= wake_len_nxt;
  end

  halt_four_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R08
    $fell(asleep_r) && !$past(reset_i) |-> halt_r [*4] ##1 !halt_r)
    else $error("halt after wake not four cycles");
  entry_active_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R02
    (state_r == SCC_ST_DRAIN) |-> $past(state_r) == SCC_ST_ACTIVE || $past(state_r) == SCC_ST_DRAIN)
    else $error("sleep entered from non-active state");
  need_enable_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R18
    (state_r == SCC_ST_ACTIVE && sleep_instr_i && !sleep_en_i) |=> state_r == SCC_ST_ACTIVE)
    else $error("sleep taken while disabled");
  stop_exec_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R03
    asleep_r |-> halt_r && !clk_r.cpu)
    else $error("core running while asleep");
  nvm_drain_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R11
    (state_r == SCC_ST_DRAIN && nvm_busy_i) |=> !asleep_r && clk_r.nvm)
    else $error("nvm clock stopped during programming");
  idle_run_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R12
    (asleep_r && mode_r == SCC_MODE_IDLE) |-> clk_r.periph && clk_r.rtc)
    else $error("idle stopped peripherals");
  pdown_stop_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R13
    (asleep_r && mode_r == SCC_MODE_PDOWN) |-> clk_r == scc_clk_s'(4'h0))
    else $error("power-down left a clock running");
  pdown_wake_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R14
    (state_r == SCC_ST_SLEEP && mode_r == SCC_MODE_PDOWN && wake_i == scc_wake_s'(4'h1)) |=> asleep_r)
    else $error("power-down woke on disallowed source");
  match_wake_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R15
    (state_r == SCC_ST_SLEEP && wake_i.wire_match) |=> !asleep_r ##4 wake_irq_o)
    else $error("address match did not wake");
  gate_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R16
    (|(reduce_i & $past(reduce_i))) && !$past(reset_i) |-> ~|(periph_clk_en_o & $past(reduce_i)))
    else $error("reduced peripheral clock running");
  drain_take_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R02
    (state_r == SCC_ST_ACTIVE && sleep_instr_i && sleep_en_i && mode_ok && !reset_i)
    |=> state_r == SCC_ST_DRAIN && halt_r)
    else $error("enabled sleep not taken");
  bad_mode_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R01
    (state_r == SCC_ST_ACTIVE && !mode_ok && !reset_i)
    |=> state_r == SCC_ST_ACTIVE && !halt_r)
    else $error("sleep taken with undefined mode");
  stay_asleep_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R03
    (state_r == SCC_ST_SLEEP && !wake_ok && !reset_i)
    |=> state_r == SCC_ST_SLEEP && asleep_r && halt_r)
    else $error("left sleep without a wake source");
  wake_restore_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R04
    (state_r == SCC_ST_SLEEP && wake_ok && !reset_i)
    |=> !asleep_r && halt_r && clk_r == scc_clk_s'(SCC_CLK_RST))
    else $error("clocks not restored on wake");
  any_wake_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R05
    (state_r == SCC_ST_SLEEP && mode_r != SCC_MODE_PDOWN && (|wake_i) && !reset_i)
    |=> !asleep_r)
    else $error("enabled interrupt did not wake");
  wake_pulse_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R06
    wirq_r
    |-> !halt_r && !asleep_r && state_r == SCC_ST_ACTIVE ##1 !wirq_r)
    else $error("release pulse malformed");
  halt_len_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R08
    wirq_r
    |-> wake_len_r == 3'(SCC_WAKE_HALT_CYC))
    else $error("halted cycles after wake wrong");
  mode_hold_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R09
    (state_r != SCC_ST_ACTIVE && !reset_i)
    |=> $stable(mode_r))
    else $error("mode changed while asleep");
  reset_state_a: assert property (@(posedge clk_sys_i) // see R10
    reset_i
    |=> state_r == SCC_ST_ACTIVE && !asleep_r && !halt_r && !wirq_r && clk_r == scc_clk_s'(SCC_CLK_RST))
    else $error("reset did not return to active");
  drain_order_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R11
    $rose(asleep_r) && !$past(reset_i)
    |-> $past(state_r) == SCC_ST_DRAIN && !$past(nvm_busy_i))
    else $error("slept before programming finished");
  gate_run_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R17
    ((asleep_r && mode_r == SCC_MODE_IDLE) || (state_r == SCC_ST_ACTIVE && $past(state_r) == SCC_ST_ACTIVE))
    && !$past(reset_i) |-> periph_clk_en_o == ~$past(reduce_i))
    else $error("gating wrong in active or idle");
  pdown_gate_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R13
    asleep_r && mode_r == SCC_MODE_PDOWN
    |-> periph_clk_en_o == '0)
    else $error("peripheral clock running in power-down");
  stop_mask_a: assert property (@(posedge clk_sys_i) disable iff (reset_i) // see R19
    asleep_r && mode_r == SCC_MODE_PSAVE
    |-> clk_r == scc_clk_s'(~PSAVE_STOP))
    else $error("power-save clocks differ from mask");

  sleep_idle_c: cover property (@(posedge clk_sys_i) asleep_r && mode_r == SCC_MODE_IDLE);
  sleep_pdown_c: cover property (@(posedge clk_sys_i) asleep_r && mode_r == SCC_MODE_PDOWN);
  wake_done_c: cover property (@(posedge clk_sys_i) wirq_r);
  reset_sleep_c: cover property (@(posedge clk_sys_i) asleep_r && reset_i);
  refuse_mode_c: cover property (@(posedge clk_sys_i) state_r == SCC_ST_ACTIVE && sleep_instr_i && sleep_en_i && !mode_ok);

endmodule : scc_sleep_ctrl
`default_nettype wire

/* tb/scc_core_model.sv */
`timescale 1ns/1ns
`default_nettype none
module scc_core_model
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Bench request
  input wire logic go_i,
  input wire logic [3:0] prog_cyc_i,
  // Toward controller
  output logic sleep_instr_o,
  output logic nvm_busy_o
);
  logic [3:0] prog_r;
  logic [3:0] prog_nxt;
  // Programming may still run when sleep is issued
  always_comb
  begin
    prog_nxt = (prog_r != 4'h0) ? prog_r - 4'h1 : 4'h0;
    if (go_i)
      prog_nxt = prog_cyc_i;
  end
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      prog_r <= 4'h0;
      sleep_instr_o <= 1'b0;
    end
    else
    begin
      prog_r <= prog_nxt;
      sleep_instr_o <= go_i;
    end
  end
  assign nvm_busy_o = (prog_r != 4'h0);
endmodule : scc_core_model
`default_nettype wire

/* tb/test_scc_sleep_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module test_scc_sleep_ctrl
  import scc_pkg::*;
;
  logic clk, rst, sleep_en, go, sleep_instr, nvm_busy, cpu_halt, asleep, wake_irq;
  logic [2:0] mode;
  logic [3:0] prog;
  logic [7:0] reduce, periph_en;
  scc_wake_s wake;
  scc_clk_s clk_en;
  int bad_count = 0;
  int comparisons = 0;
  scc_core_model core (.clk_sys_i(clk), .reset_i(rst), .go_i(go), .prog_cyc_i(prog),
    .sleep_instr_o(sleep_instr), .nvm_busy_o(nvm_busy));
  scc_sleep_ctrl uut (.clk_sys_i(clk), .reset_i(rst), .sleep_en_i(sleep_en), .sleep_mode_i(mode),
    .reduce_i(reduce), .sleep_instr_i(sleep_instr), .nvm_busy_i(nvm_busy), .wake_i(wake),
    .cpu_halt_o(cpu_halt), .asleep_o(asleep), .wake_irq_o(wake_irq), .clk_en_o(clk_en),
    .periph_clk_en_o(periph_en));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    begin
      comparisons++;
      if (got !== exp)
      begin
        bad_count++;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask : chk
  task tally_and_finish;
    begin
      $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask : tally_and_finish
  task pulse(input logic [2:0] m, input logic [3:0] pc);
    begin
      @(posedge clk) mode <= m;
      prog <= pc;
      @(posedge clk) go <= 1'b1;
      @(posedge clk) go <= 1'b0;
    end
  endtask : pulse
  task enter(input logic [2:0] m, input logic [3:0] pc);
    int n;
    begin
      pulse(m, pc);
      n = 0;
      while (asleep !== 1'b1 && n < 20)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      chk({cpu_halt, asleep, nvm_busy}, 3'b110);
    end
  endtask : enter
  task run(input logic [2:0] m, input logic [3:0] ek, input logic [3:0] w, input logic [3:0] pc);
    begin
      enter(m, pc);
      @(posedge clk);
      #1 chk({clk_en, periph_en}, {ek, ek[1] ? ~reduce : 8'h00});
      if (m == SCC_MODE_PDOWN)
      begin
        @(posedge clk) wake <= 4'h1;
        repeat (3) @(posedge clk);
        #1 chk({asleep, cpu_halt}, 2'b11);
      end
      @(posedge clk) wake <= w;
      @(posedge clk) wake <= 4'h0;
      #1 chk({asleep, clk_en, cpu_halt, wake_irq}, 7'h3E);
      repeat (3) @(posedge clk);
      #1 chk({cpu_halt, wake_irq}, 2'b10);
      @(posedge clk);
      #1 chk({cpu_halt, wake_irq}, 2'b01);
      @(posedge clk);
      #1 chk({cpu_halt, wake_irq}, 2'b00);
    end
  endtask : run
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Sequence needs under two hundred cycles
  initial
  begin
    #100000;
    bad_count++;
    tally_and_finish();
  end
  initial
  begin
    rst = 1'b1;
    sleep_en = 1'b0;
    go = 1'b0;
    mode = 3'h0;
    prog = 4'h0;
    reduce = 8'h00;
    wake = 4'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({cpu_halt, asleep, wake_irq, clk_en, periph_en}, 15'h0FFF);
    pulse(SCC_MODE_IDLE, 4'h0);
    repeat (3) @(posedge clk);
    #1 chk(cpu_halt, 1'b0);
    @(posedge clk) sleep_en <= 1'b1;
    pulse(3'h1, 4'h0);
    repeat (3) @(posedge clk);
    #1 chk(cpu_halt, 1'b0);
    @(posedge clk) reduce <= 8'h5A;
    repeat (2) @(posedge clk);
    #1 chk(periph_en, 8'hA5);
    run(SCC_MODE_IDLE, 4'h3, 4'h1, 4'h4);
    run(SCC_MODE_PDOWN, 4'h0, 4'h4, 4'h0);
    run(SCC_MODE_PDOWN, 4'h0, 4'h2, 4'h0);
    run(SCC_MODE_PDOWN, 4'h0, 4'h8, 4'h0);
    run(SCC_MODE_PSAVE, 4'h3, 4'h8, 4'h0);
    run(SCC_MODE_STDBY, 4'h3, 4'h8, 4'h0);
    run(SCC_MODE_ESTDBY, 4'h3, 4'h1, 4'h0);
    enter(SCC_MODE_PDOWN, 4'h0);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    #1 chk({cpu_halt, asleep, wake_irq, clk_en}, 7'h0F);
    @(posedge clk);
    #1 chk(periph_en, 8'hA5);
    tally_and_finish();
  end
endmodule : test_scc_sleep_ctrl
`default_nettype wire
